// file: include/bbc_pkg.sv
// Purpose: Shared constants and types for the buck-boost configuration register bank
// Assumes: Byte-wide registers reached through the serial management target
// Notes: Field positions and reset values are used by the bank and by the top

package bbc_pkg;

    localparam logic [7:0] OFS_FB_DRV = 8'hd8;
    localparam logic [7:0] OFS_CUR_WIN = 8'hd9;
    localparam logic [7:0] OFS_OVP = 8'hda;

    localparam logic [7:0] RST_FB_DRV = 8'h84;
    localparam logic [7:0] RST_CUR_WIN = 8'h2c;
    localparam logic [7:0] RST_OVP = 8'hff;

    // Bits that hold state; the rest read as zero
    localparam logic [7:0] MASK_FB_DRV = 8'hff;
    localparam logic [7:0] MASK_CUR_WIN = 8'h3f;
    localparam logic [7:0] MASK_OVP = 8'hff;

    localparam int FB_DIV_BIT = 7;
    localparam int CDC_EN_BIT = 6;
    localparam int GAIN_LSB = 4;
    localparam int SEQ_LSB = 2;
    localparam int SUP_LSB = 0;
    localparam int CUR_SEL_BIT = 5;
    localparam int WIN_LSB = 0;

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef struct packed {
        logic feedback_divider_select;
        logic cable_comp_enable;
        logic [1:0] cable_comp_gain;
        logic [1:0] aux_driver_sequence;
        logic [1:0] aux_driver_supply;
        logic current_set_pin_select;
        logic [4:0] window_low_threshold;
        logic [7:0] input_ovp_threshold;
    } bbc_cfg_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } bbc_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_REG = 4'h2,
        ST_REG_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RDATA_ACK = 4'hc
    } bbc_state_t;

    function automatic logic is_mapped(logic [7:0] a);
        is_mapped = (a == OFS_FB_DRV) || (a == OFS_CUR_WIN) || (a == OFS_OVP);
    endfunction

endpackage

// file: rtl/bbc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs
// Assumes: Each bit is an independent level
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ns

module bbc_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    if (W < 1) begin : g_chk
        $error("bbc_sync needs a width of at least one");
    end

    // Idle level of an open-drain bus is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '1;
            q <= '1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// file: rtl/bbc_cfg_regs.sv
// Purpose: The three configuration registers with reset values and read mux
// Assumes: One write strobe per byte from the serial target
// Notes: Unimplemented bits are masked on write so they always read zero
`timescale 1ns/1ns

module bbc_cfg_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire bbc_pkg::bbc_wr_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output bbc_pkg::bbc_cfg_t cfg
);

    logic [7:0] fb_drv_q;
    logic [7:0] cur_win_q;
    logic [7:0] ovp_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fb_drv_q <= bbc_pkg::RST_FB_DRV;
            cur_win_q <= bbc_pkg::RST_CUR_WIN;
            ovp_q <= bbc_pkg::RST_OVP;
        end else if (wr.en) begin
            if (wr.addr == bbc_pkg::OFS_FB_DRV) begin
                fb_drv_q <= wr.data & bbc_pkg::MASK_FB_DRV;
            end
            if (wr.addr == bbc_pkg::OFS_CUR_WIN) begin
                cur_win_q <= wr.data & bbc_pkg::MASK_CUR_WIN;
            end
            if (wr.addr == bbc_pkg::OFS_OVP) begin
                ovp_q <= wr.data & bbc_pkg::MASK_OVP;
            end
        end
    end

    always_comb begin
        case (rd_addr)
            bbc_pkg::OFS_FB_DRV: rd_data = fb_drv_q;
            bbc_pkg::OFS_CUR_WIN: rd_data = cur_win_q & bbc_pkg::MASK_CUR_WIN;
            bbc_pkg::OFS_OVP: rd_data = ovp_q;
            default: rd_data = 8'h00;
        endcase
    end

    assign cfg.feedback_divider_select = fb_drv_q[bbc_pkg::FB_DIV_BIT];
    assign cfg.cable_comp_enable = fb_drv_q[bbc_pkg::CDC_EN_BIT];
    assign cfg.cable_comp_gain = fb_drv_q[bbc_pkg::GAIN_LSB +: 2];
    assign cfg.aux_driver_sequence = fb_drv_q[bbc_pkg::SEQ_LSB +: 2];
    assign cfg.aux_driver_supply = fb_drv_q[bbc_pkg::SUP_LSB +: 2];
    assign cfg.current_set_pin_select = cur_win_q[bbc_pkg::CUR_SEL_BIT];
    assign cfg.window_low_threshold = cur_win_q[bbc_pkg::WIN_LSB +: 5];
    assign cfg.input_ovp_threshold = ovp_q;

endmodule

// file: rtl/bbc_top.sv
// Purpose: Buck-boost configuration bank behind a serial management target
// Assumes: Host drives SCL; target never stretches the clock
// Notes: Single pointer byte per transaction; pointer does not advance
`timescale 1ns/1ns

module bbc_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic FEEDBACK_DIVIDER_SELECT,
    output logic CABLE_COMP_ENABLE,
    output logic [1:0] CABLE_COMP_GAIN,
    output logic [1:0] AUX_DRIVER_SEQUENCE,
    output logic [1:0] AUX_DRIVER_SUPPLY,
    output logic CURRENT_SET_PIN_SELECT,
    output logic [4:0] WINDOW_LOW_THRESHOLD,
    output logic [7:0] INPUT_OVP_THRESHOLD
);

    if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_chk
        $error("DEV_ADDR falls in a reserved target address range");
    end

    bbc_pkg::bbc_state_t state_q;
    bbc_pkg::bbc_wr_t wr_q;
    bbc_pkg::bbc_cfg_t cfg;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_d_q;
    logic sda_d_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic mack_q;
    logic sda_oe_q;
    logic sda_o_q;
    logic [7:0] rd_data;

    bbc_sync #(.W(2)) u_sync (
        .clk(SYS_CLK),
        .nrst(NRST),
        .d({SCL_IN, SDA_IN}),
        .q(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    bbc_cfg_regs u_regs (
        .clk(SYS_CLK),
        .nrst(NRST),
        .wr(wr_q),
        .rd_addr(ptr_q),
        .rd_data(rd_data),
        .cfg(cfg)
    );

    // Delayed copies for edge and bus condition detection
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_q;
    assign scl_fall = ~scl_s & scl_d_q;
    assign start_seen = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_seen = scl_s & scl_d_q & ~sda_d_q & sda_s;

    // Open drain: the pad only ever pulls low
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= bbc_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_q <= '0;
        end else begin
            wr_q.en <= 1'b0;
            if (stop_seen) begin
                state_q <= bbc_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_seen) begin
                // Repeated start keeps the pointer for a following read
                state_q <= bbc_pkg::ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    bbc_pkg::ST_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    bbc_pkg::ST_ADDR, bbc_pkg::ST_REG, bbc_pkg::ST_WDATA: begin
                        if (scl_rise && cnt_q != bbc_pkg::BYTE_BITS) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == bbc_pkg::BYTE_BITS) begin
                            cnt_q <= 4'h0;
                            sda_oe_q <= 1'b1;
                            if (state_q == bbc_pkg::ST_ADDR) begin
                                if (shift_q[7:1] == DEV_ADDR) begin
                                    rw_q <= shift_q[0];
                                    state_q <= bbc_pkg::ST_ADDR_ACK;
                                end else begin
                                    sda_oe_q <= 1'b0;
                                    state_q <= bbc_pkg::ST_IDLE;
                                end
                            end else if (state_q == bbc_pkg::ST_REG) begin
                                ptr_q <= shift_q;
                                state_q <= bbc_pkg::ST_REG_ACK;
                            end else begin
                                // Byte complete: apply it now
                                wr_q.en <= 1'b1;
                                wr_q.addr <= ptr_q;
                                wr_q.data <= shift_q;
                                state_q <= bbc_pkg::ST_WDATA_ACK;
                            end
                        end
                    end
                    bbc_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                shift_q <= rd_data;
                                sda_oe_q <= ~rd_data[7];
                                state_q <= bbc_pkg::ST_RDATA;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q <= bbc_pkg::ST_REG;
                            end
                        end
                    end
                    bbc_pkg::ST_REG_ACK, bbc_pkg::ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            state_q <= bbc_pkg::ST_WDATA;
                        end
                    end
                    bbc_pkg::ST_RDATA: begin
                        if (scl_fall) begin
                            if (cnt_q == bbc_pkg::LAST_BIT) begin
                                cnt_q <= 4'h0;
                                sda_oe_q <= 1'b0;
                                state_q <= bbc_pkg::ST_RDATA_ACK;
                            end else begin
                                cnt_q <= cnt_q + 4'h1;
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= ~shift_q[6];
                            end
                        end
                    end
                    bbc_pkg::ST_RDATA_ACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s;
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                // Same register again; pointer does not advance
                                shift_q <= rd_data;
                                sda_oe_q <= ~rd_data[7];
                                state_q <= bbc_pkg::ST_RDATA;
                            end else begin
                                state_q <= bbc_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                        state_q <= bbc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign SDA_OUT = sda_o_q;
    assign SDA_OE = sda_oe_q;
    assign FEEDBACK_DIVIDER_SELECT = cfg.feedback_divider_select;
    assign CABLE_COMP_ENABLE = cfg.cable_comp_enable;
    assign CABLE_COMP_GAIN = cfg.cable_comp_gain;
    assign AUX_DRIVER_SEQUENCE = cfg.aux_driver_sequence;
    assign AUX_DRIVER_SUPPLY = cfg.aux_driver_supply;
    assign CURRENT_SET_PIN_SELECT = cfg.current_set_pin_select;
    assign WINDOW_LOW_THRESHOLD = cfg.window_low_threshold;
    assign INPUT_OVP_THRESHOLD = cfg.input_ovp_threshold;

    // Checks: a first-cycle marker lets reset values be seen after release
    logic first_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sequence wr_fb;
        wr_q.en && wr_q.addr == bbc_pkg::OFS_FB_DRV;
    endsequence

    fb_divider_a: assert property (wr_fb |=> FEEDBACK_DIVIDER_SELECT == $past(wr_q.data[7]))
        else $error("divider select did not follow write");
    cdc_enable_a: assert property (wr_fb |=> CABLE_COMP_ENABLE == $past(wr_q.data[6]))
        else $error("cable compensation enable did not follow write");
    comp_gain_a: assert property (wr_fb |=> CABLE_COMP_GAIN == $past(wr_q.data[5:4]))
        else $error("cable compensation gain did not follow write");
    drv_seq_a: assert property (wr_fb |=> AUX_DRIVER_SEQUENCE == $past(wr_q.data[3:2]))
        else $error("driver sequencing did not follow write");
    drv_supply_a: assert property (wr_fb |=> AUX_DRIVER_SUPPLY == $past(wr_q.data[1:0]))
        else $error("driver supply did not follow write");
    unused_bits_a: assert property (ptr_q == bbc_pkg::OFS_CUR_WIN |-> rd_data[7:6] == 2'b00)
        else $error("unimplemented bits read nonzero");
    cur_pin_a: assert property (wr_q.en && wr_q.addr == bbc_pkg::OFS_CUR_WIN
        |=> CURRENT_SET_PIN_SELECT == $past(wr_q.data[5]))
        else $error("current set pin select did not follow write");
    window_low_a: assert property (wr_q.en && wr_q.addr == bbc_pkg::OFS_CUR_WIN
        |=> WINDOW_LOW_THRESHOLD == $past(wr_q.data[4:0]))
        else $error("window threshold did not follow write");
    ovp_thresh_a: assert property (wr_q.en && wr_q.addr == bbc_pkg::OFS_OVP
        |=> INPUT_OVP_THRESHOLD == $past(wr_q.data))
        else $error("overvoltage threshold did not follow write");
    reset_vals_a: assert property (first_q |->
        {FEEDBACK_DIVIDER_SELECT, CABLE_COMP_ENABLE, CABLE_COMP_GAIN, AUX_DRIVER_SEQUENCE,
        AUX_DRIVER_SUPPLY} == bbc_pkg::RST_FB_DRV
        && {2'b00, CURRENT_SET_PIN_SELECT, WINDOW_LOW_THRESHOLD} == bbc_pkg::RST_CUR_WIN)
        else $error("configuration reset values wrong");
    ovp_reset_a: assert property (first_q |-> INPUT_OVP_THRESHOLD == bbc_pkg::RST_OVP)
        else $error("threshold reset value wrong");
    write_ack_a: assert property (wr_q.en |->
        state_q == bbc_pkg::ST_WDATA_ACK && SDA_OE ##1 !wr_q.en)
        else $error("write strobe without acknowledge");
    stable_a: assert property (!wr_q.en |=> $stable(INPUT_OVP_THRESHOLD))
        else $error("threshold changed without a write");
    fb_hold_a: assert property (!wr_q.en |=>
        $stable({FEEDBACK_DIVIDER_SELECT, CABLE_COMP_ENABLE, CABLE_COMP_GAIN,
        AUX_DRIVER_SEQUENCE, AUX_DRIVER_SUPPLY}))
        else $error("driver configuration changed without a write");
    win_hold_a: assert property (!wr_q.en |=>
        $stable({CURRENT_SET_PIN_SELECT, WINDOW_LOW_THRESHOLD}))
        else $error("current set window changed without a write");

    // Read path must mirror the outputs, so a stale or mis-decoded mux shows up here
    fb_read_a: assert property (ptr_q == bbc_pkg::OFS_FB_DRV |->
        rd_data == {FEEDBACK_DIVIDER_SELECT, CABLE_COMP_ENABLE, CABLE_COMP_GAIN,
        AUX_DRIVER_SEQUENCE, AUX_DRIVER_SUPPLY})
        else $error("read data differs from driver configuration");
    win_read_a: assert property (ptr_q == bbc_pkg::OFS_CUR_WIN |->
        rd_data == {2'b00, CURRENT_SET_PIN_SELECT, WINDOW_LOW_THRESHOLD})
        else $error("read data differs from current set window");
    ovp_read_a: assert property (ptr_q == bbc_pkg::OFS_OVP |->
        rd_data == INPUT_OVP_THRESHOLD)
        else $error("read data differs from threshold");
    idle_quiet_a: assert property (state_q == bbc_pkg::ST_IDLE |-> !SDA_OE)
        else $error("data line driven while idle");
    host_ack_a: assert property (state_q == bbc_pkg::ST_RDATA_ACK |-> !SDA_OE)
        else $error("data line driven during host acknowledge");

    wr_fb_c: cover property (wr_fb);
    rd_byte_c: cover property (state_q == bbc_pkg::ST_RDATA_ACK && scl_fall && mack_q);
    nack_c: cover property (state_q == bbc_pkg::ST_ADDR && scl_fall
        && cnt_q == bbc_pkg::BYTE_BITS && shift_q[7:1] != DEV_ADDR);
    unmapped_c: cover property (wr_q.en && !bbc_pkg::is_mapped(wr_q.addr));
    ovp_wr_c: cover property (wr_q.en && wr_q.addr == bbc_pkg::OFS_OVP);

endmodule

// file: dv/testbench.sv
// Purpose: Self-checking bench for the configuration bank behind its serial target
// Assumes: Host clocks SCL with 6 clk low and 8 clk high phases; SDA has a pull-up
// Notes: Expected values come from the register table and the package masks
`timescale 1ns/1ns

module testbench;
    localparam logic [6:0] DEV = 7'h2a; // Arbitrary target address
    logic sys_clk;
    logic nrst;
    logic scl;
    logic sda_host;
    logic sda_wire;
    logic sda_oe;
    logic sda_out;
    logic fb_div;
    logic cc_en;
    logic [1:0] cc_gain;
    logic [1:0] seq;
    logic [1:0] sup;
    logic cur_sel;
    logic [4:0] win;
    logic [7:0] ovp;
    int n_fail;
    int total_checks;

    // Open-drain wire with pull-up: the device shows its pad value only while enabled
    assign sda_wire = sda_host & (~sda_oe | sda_out);

    bbc_top #(.DEV_ADDR(DEV)) bbc_top_inst (
        .SYS_CLK(sys_clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .FEEDBACK_DIVIDER_SELECT(fb_div),
        .CABLE_COMP_ENABLE(cc_en), .CABLE_COMP_GAIN(cc_gain), .AUX_DRIVER_SEQUENCE(seq),
        .AUX_DRIVER_SUPPLY(sup), .CURRENT_SET_PIN_SELECT(cur_sel),
        .WINDOW_LOW_THRESHOLD(win), .INPUT_OVP_THRESHOLD(ovp)
    );

    function automatic logic [7:0] out_byte(input logic [7:0] a);
        case (a)
            bbc_pkg::OFS_FB_DRV: out_byte = {fb_div, cc_en, cc_gain, seq, sup};
            bbc_pkg::OFS_CUR_WIN: out_byte = {2'b00, cur_sel, win};
            bbc_pkg::OFS_OVP: out_byte = ovp;
            default: out_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] exp_mask(input logic [7:0] a);
        case (a)
            bbc_pkg::OFS_FB_DRV: exp_mask = bbc_pkg::MASK_FB_DRV;
            bbc_pkg::OFS_CUR_WIN: exp_mask = bbc_pkg::MASK_CUR_WIN;
            bbc_pkg::OFS_OVP: exp_mask = bbc_pkg::MASK_OVP;
            default: exp_mask = 8'h00;
        endcase
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic end_test(input string name);
        $display("test done: %s, mismatches so far %0d", name, n_fail);
    endtask

    // SDA only moves 2 clk after SCL falls, so the synced pins never look like START
    task automatic bit_slot(input logic b, output logic s);
        sda_host = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        s = sda_wire;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], s);
            rx[i] = s;
        end
        bit_slot(ack_in, s);
        ack = ~s;
    endtask

    task automatic bus_start();
        sda_host = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_host = 1'b0;
        tick(6);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic bus_stop();
        sda_host = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_host = 1'b1;
        tick(6);
    endtask

    task automatic send_hdr(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic ack;
        xfer(b, 1'b1, rx, ack);
        chk1("ack", exp_ack, ack);
    endtask

    // Outputs must already hold the new field at the end of the data byte
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        bus_start();
        send_hdr({DEV, 1'b0}, 1'b1);
        send_hdr(a, 1'b1);
        send_hdr(d, 1'b1);
        chk8("field outputs", d & exp_mask(a), out_byte(a));
        bus_stop();
    endtask

    // Host acks the first byte, so the same register must come back once more
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        logic [7:0] rx2;
        logic ack;
        bus_start();
        send_hdr({DEV, 1'b0}, 1'b1);
        send_hdr(a, 1'b1);
        bus_start();
        send_hdr({DEV, 1'b1}, 1'b1);
        xfer(8'hff, 1'b0, rx, ack);
        xfer(8'hff, 1'b1, rx2, ack);
        bus_stop();
        chk8("read data", exp, rx);
        chk8("read data repeated", exp, rx2);
    endtask

    task automatic check_resets();
        chk8("out feedback_driver_config", 8'h84, out_byte(bbc_pkg::OFS_FB_DRV));
        chk8("out current_set_window", 8'h2c, out_byte(bbc_pkg::OFS_CUR_WIN));
        chk8("out input_ovp_threshold", 8'hff, out_byte(bbc_pkg::OFS_OVP));
        chk1("sda pull level", 1'b0, sda_out);
        chk1("sda released", 1'b0, sda_oe);
        reg_read(bbc_pkg::OFS_FB_DRV, 8'h84);
        reg_read(bbc_pkg::OFS_CUR_WIN, 8'h2c);
        reg_read(bbc_pkg::OFS_OVP, 8'hff);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // A full run needs about 21300 clk; four times that means a hang
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_fail++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        logic [1:0] c;
        logic [7:0] v;
        logic [7:0] wv[4];
        logic [7:0] ov[4];
        wv = '{8'hff, 8'h00, 8'hcc, 8'h41};
        ov = '{8'h00, 8'h3f, 8'hff, 8'h80};
        nrst = 1'b0;
        scl = 1'b1;
        sda_host = 1'b1;
        n_fail = 0;
        total_checks = 0;
        repeat (2) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        tick(3);
        check_resets();
        end_test("reset values");
        // Every code of every field; the sequence field takes the inverse of the gain and supply code
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            v = {c[1], c[0], c, ~c, c};
            reg_write(bbc_pkg::OFS_FB_DRV, v);
            reg_read(bbc_pkg::OFS_FB_DRV, v);
        end
        end_test("feedback and driver fields");
        for (int i = 0; i < 4; i++) begin
            reg_write(bbc_pkg::OFS_CUR_WIN, wv[i]);
            reg_read(bbc_pkg::OFS_CUR_WIN, wv[i] & 8'h3f);
        end
        end_test("current set and window");
        for (int i = 0; i < 4; i++) begin
            reg_write(bbc_pkg::OFS_OVP, ov[i]);
            reg_read(bbc_pkg::OFS_OVP, ov[i]);
        end
        end_test("overvoltage threshold");
        // Second data byte goes to the same pointer and wins
        bus_start();
        send_hdr({DEV, 1'b0}, 1'b1);
        send_hdr(bbc_pkg::OFS_CUR_WIN, 1'b1);
        send_hdr(8'h01, 1'b1);
        send_hdr(8'hfe, 1'b1);
        bus_stop();
        reg_read(bbc_pkg::OFS_CUR_WIN, 8'h3e);
        end_test("back to back bytes");
        // Foreign address: no ack and no write even if the host keeps going
        bus_start();
        send_hdr({DEV ^ 7'h01, 1'b0}, 1'b0);
        send_hdr(bbc_pkg::OFS_OVP, 1'b0);
        send_hdr(8'h11, 1'b0);
        bus_stop();
        reg_read(bbc_pkg::OFS_OVP, 8'h80);
        reg_write(8'hdb, 8'h5a);
        reg_read(8'hdb, 8'h00);
        reg_read(bbc_pkg::OFS_FB_DRV, 8'hf3);
        end_test("foreign address and unmapped pointer");
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(3);
        check_resets();
        end_test("reset in mid run");
        summarize();
    end
endmodule
